/* src/adc_seq_defines.svh */
// offsets, field positions and cycle counts of the converter sequencer
// assumes: included by bare name from the design files
`ifndef ADC_SEQ_DEFINES_SVH
`define ADC_SEQ_DEFINES_SVH

// register byte offsets, one 32-bit word each except RES_OFS, which starts eight result words
`define CTRL_OFS 6'h00
`define STAT_OFS 6'h04
`define RES_OFS 6'h20

// control register fields
`define CTRL_START 0
`define CTRL_EXT_TRIG 1
`define CTRL_RES10 2
`define CTRL_SH 3
`define CTRL_FREQ_LO 4
`define CTRL_FREQ_HI 5
`define CTRL_CHAN_LSB 6
`define CTRL_CHAN_MSB 8
`define CTRL_ROUTE_LSB 9
`define CTRL_ROUTE_MSB 10
`define CTRL_VREF 11
`define CTRL_W 12
`define CTRL_RESET 12'h000

// status register fields
`define STAT_BUSY 0
`define STAT_IRQ 1
`define STAT_TRIG 2

// timing in operation-clock cycles
`define SH_CYC_10 6'd33
`define SH_CYC_8 6'd28
`define NOSH_CYC_10 6'd59
`define NOSH_CYC_8 6'd49
`define SAMPLE_CYC 6'd3
`define STEP_LAST 2'd2
`define DIV4_LAST 2'd3
`define DIV2_LAST 2'd1
`define DIV1_LAST 2'd0

// successive-approximation layout
`define SAR_W 10
`define SAR_MSB 10'h200
`define CHAN_N 8

`endif

/* src/adc_seq_pkg.sv */
// types shared by the converter sequencer and its result memory
// assumes: compiled before every design module
package adc_seq_pkg;

  typedef enum logic {ST_IDLE, ST_CONV} conv_state_t;

  typedef enum logic [1:0] {BUS_IDLE, BUS_WAIT, BUS_ACK} bus_phase_t;

  // control field value that picks the converter input
  typedef enum logic [1:0]
  {
    ROUTE_STD,
    ROUTE_EXPANDED_IO_PIN_0,
    ROUTE_EXPANDED_INPUT_PIN_1,
    ROUTE_OPAMP
  } input_route_t;

endpackage : adc_seq_pkg

/* src/adc_result_mem.sv */
// eight conversion result words, one per standard channel
// assumes: single clock, read data registered, one write port
`include "adc_seq_defines.svh"

module adc_result_mem import adc_seq_pkg::*;
(
  input wire logic core_clk_i,
  input wire logic reset_n_i,
  input wire logic we_i,
  input wire logic [2:0] waddr_i,
  input wire logic [`SAR_W-1:0] wdata_i,
  input wire logic [2:0] raddr_i,
  output logic [`SAR_W-1:0] rdata_o
);

  logic [`SAR_W-1:0] words [`CHAN_N];

  // cleared at reset so a read before the first conversion gives zero
  always_ff @(posedge core_clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      for (int i = 0; i < `CHAN_N; i++)
      begin
        words[i] <= '0;
      end
      rdata_o <= '0;
    end
    else
    begin
      if (we_i)
      begin
        words[waddr_i] <= wdata_i;
      end
      rdata_o <= words[raddr_i];
    end
  end

endmodule : adc_result_mem

/* src/adc_seq_oneshot.sv */
// one-shot sequencer of an eight-channel successive-approximation converter
// assumes: avalon-mm master on core_clk_i; comparator and trigger are async pins
//
// Chosen here: the Avalon-MM slave port and the address map.
`include "adc_seq_defines.svh"

// Notes on behaviour
// - freq bits 00 divide by four, 01 by two, 1x undivided
// - a channel needs at least 28 (8-bit) or 33 (10-bit) cycles
// - without sample-and-hold a conversion takes 59 (10-bit) or 49 (8-bit) cycles
// - with sample-and-hold the input is sampled the first 3 cycles
// - 8-bit mode resolves only the upper 8 of 10 approximation bits
// - codes span 0..1023 or 0..255 with half-step offset
// - conversions start from the software flag or the external trigger pin
// - op-amp mode drives channel out expanded pin 0, converts expanded pin 1
// - expanded-input mode converts one expanded pin instead of the channels
// - exactly one of eight standard channels is selected
// - software trigger: writing start flag 1 starts one conversion
// - on completion: store result, set request bit, clear start flag, halt
// - external trigger: falling pin edge with start flag 1 starts
// - external completion stores, requests, then waits for the next edge
// - an edge during conversion aborts it and restarts from the beginning
// - with sample-and-hold: 33 cycles at 10-bit, 28 at 8-bit
// - the source clock equals the main clock
module adc_seq_oneshot import adc_seq_pkg::*;
(
  input wire logic core_clk_i,
  input wire logic reset_n_i,
  input wire logic [5:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  input wire logic [3:0] avs_byteenable_i,
  output logic [31:0] avs_readdata_o,
  output logic avs_waitrequest_o,
  input wire logic ext_start_trigger_pin_i,
  input wire logic comparator_i,
  output logic sample_o,
  output logic [`SAR_W-1:0] dac_code_o,
  output logic [2:0] channel_sel_o,
  output logic [1:0] input_route_o,
  output logic chan_to_expanded_io_pin_0_o,
  output logic vref_connect_o,
  output logic irq_request_o,
  output logic busy_o
);

  function automatic logic [5:0] conv_total(input logic sh, input logic res10);
    if (sh)
    begin
      conv_total = res10 ? `SH_CYC_10 : `SH_CYC_8;
    end
    else
    begin
      conv_total = res10 ? `NOSH_CYC_10 : `NOSH_CYC_8;
    end
  endfunction : conv_total

  function automatic logic [31:0] lane_merge(input logic [31:0] old, input logic [31:0] wd,
                                             input logic [3:0] be);
    for (int i = 0; i < 4; i++)
    begin
      lane_merge[i*8 +: 8] = be[i] ? wd[i*8 +: 8] : old[i*8 +: 8];
    end
  endfunction : lane_merge

  // synchronisers; first stages feed only second stages
  logic trig_s1;
  logic trig_s2;
  logic trig_prev;
  logic cmp_s1;
  logic cmp_s2;

  bus_phase_t bus;
  bus_phase_t next_bus;
  logic [31:0] next_readdata;
  logic next_waitrequest;
  logic [31:0] read_mux;
  logic [`SAR_W-1:0] mem_rdata;

  logic [`CTRL_W-1:0] ctrl;
  logic [`CTRL_W-1:0] next_ctrl;
  logic [`CTRL_W-1:0] new_ctrl;
  logic [31:0] merged_ctrl;
  logic next_irq;
  conv_state_t state;
  conv_state_t next_state;
  logic [5:0] cyc;
  logic [5:0] next_cyc;
  logic [1:0] sub;
  logic [1:0] next_sub;
  logic [`SAR_W-1:0] sar;
  logic [`SAR_W-1:0] next_sar;
  logic [`SAR_W-1:0] mask;
  logic [`SAR_W-1:0] next_mask;
  logic [1:0] div_cnt;
  logic [1:0] next_div;
  logic [1:0] div_last;

  logic bus_wr;
  logic ctrl_wr;
  logic stat_wr;
  logic phi_tick;
  logic trig_fall;
  logic bits_done;
  logic sw_go;
  logic ext_go;
  logic done;
  logic mem_we;
  logic [2:0] mem_waddr;
  logic [`SAR_W-1:0] mem_wdata;
  logic [5:0] total;
  input_route_t route;

  adc_result_mem u_results
  (
    .core_clk_i(core_clk_i),
    .reset_n_i(reset_n_i),
    .we_i(mem_we),
    .waddr_i(mem_waddr),
    .wdata_i(mem_wdata),
    .raddr_i(avs_address_i[4:2]),
    .rdata_o(mem_rdata)
  );

  // ---------------- register bus ----------------
  // every access answers on the third edge; unmapped reads give zero
  assign bus_wr = (bus == BUS_ACK) && avs_write_i;
  assign ctrl_wr = bus_wr && (avs_address_i == `CTRL_OFS);
  assign stat_wr = bus_wr && (avs_address_i == `STAT_OFS);
  assign merged_ctrl = lane_merge({20'h00000, ctrl}, avs_writedata_i, avs_byteenable_i);
  assign new_ctrl = merged_ctrl[`CTRL_W-1:0];

  always_comb
  begin
    read_mux = 32'h00000000;
    if (avs_address_i == `CTRL_OFS)
    begin
      read_mux = {20'h00000, ctrl};
    end
    else if (avs_address_i == `STAT_OFS)
    begin
      read_mux[`STAT_BUSY] = (state == ST_CONV);
      read_mux[`STAT_IRQ] = irq_request_o;
      read_mux[`STAT_TRIG] = trig_s2;
    end
    else if (avs_address_i[5] && avs_address_i[1:0] == 2'b00)
    begin
      read_mux = {22'h000000, mem_rdata};
    end
  end

  always_comb
  begin
    next_bus = bus;
    next_readdata = avs_readdata_o;
    unique case (bus)
      BUS_IDLE:
      begin
        if (avs_read_i || avs_write_i)
        begin
          next_bus = BUS_WAIT;
        end
      end
      BUS_WAIT:
      begin
        next_bus = BUS_ACK;
        next_readdata = avs_read_i ? read_mux : 32'h00000000;
      end
      BUS_ACK:
      begin
        next_bus = BUS_IDLE;
      end
    endcase
    next_waitrequest = (next_bus != BUS_ACK);
  end

  // ---------------- conversion sequencer ----------------
  always_comb
  begin
    unique case ({ctrl[`CTRL_FREQ_HI], ctrl[`CTRL_FREQ_LO]})
      2'b00: div_last = `DIV4_LAST;
      2'b01: div_last = `DIV2_LAST;
      default: div_last = `DIV1_LAST;
    endcase
  end

  // source clock is the core clock itself
  assign phi_tick = (div_cnt == div_last);
  assign trig_fall = trig_prev && !trig_s2;
  assign total = conv_total(ctrl[`CTRL_SH], ctrl[`CTRL_RES10]);
  // 8-bit mode stops once the trial mask has left the upper eight bits
  assign bits_done = ctrl[`CTRL_RES10] ? (mask == '0) : (mask[9:2] == 8'h00);
  assign route = input_route_t'(ctrl[`CTRL_ROUTE_MSB:`CTRL_ROUTE_LSB]);
  assign sw_go = ctrl_wr && new_ctrl[`CTRL_START] && !new_ctrl[`CTRL_EXT_TRIG]
                 && (state == ST_IDLE);
  assign ext_go = ctrl[`CTRL_EXT_TRIG] && ctrl[`CTRL_START] && trig_fall;

  always_comb
  begin
    next_ctrl = ctrl;
    next_irq = irq_request_o;
    next_state = state;
    next_cyc = cyc;
    next_sub = sub;
    next_sar = sar;
    next_mask = mask;
    next_div = phi_tick ? 2'd0 : 2'(div_cnt + 2'd1);
    done = 1'b0;
    mem_we = 1'b0;
    mem_wdata = '0;
    unique case (route)
      ROUTE_EXPANDED_IO_PIN_0: mem_waddr = 3'd0;
      ROUTE_EXPANDED_INPUT_PIN_1: mem_waddr = 3'd1;
      default: mem_waddr = ctrl[`CTRL_CHAN_MSB:`CTRL_CHAN_LSB];
    endcase
    if (ctrl_wr)
    begin
      next_ctrl = new_ctrl;
    end
    if (stat_wr && avs_byteenable_i[0] && avs_writedata_i[`STAT_IRQ])
    begin
      next_irq = 1'b0;
    end
    if (state == ST_CONV && phi_tick)
    begin
      next_cyc = 6'(cyc + 6'd1);
      if (cyc >= `SAMPLE_CYC && !bits_done)
      begin
        next_sub = (sub == `STEP_LAST) ? 2'd0 : 2'(sub + 2'd1);
        if (sub == `STEP_LAST)
        begin
          // decide current bit, then offer the next lower one
          next_sar = cmp_s2 ? sar : (sar & ~mask);
          next_mask = mask >> 1;
          if (ctrl[`CTRL_RES10] || next_mask[9:2] != 8'h00)
          begin
            next_sar = next_sar | next_mask;
          end
        end
      end
      if (cyc == 6'(total - 6'd1))
      begin
        done = 1'b1;
        mem_we = 1'b1;
        mem_wdata = ctrl[`CTRL_RES10] ? next_sar : {2'b00, next_sar[9:2]};
        next_state = ST_IDLE;
        next_irq = 1'b1;
        // a start written in the same cycle is kept
        if (!ctrl[`CTRL_EXT_TRIG] && !ctrl_wr)
        begin
          next_ctrl[`CTRL_START] = 1'b0;
        end
      end
    end
    if (ctrl_wr && !new_ctrl[`CTRL_START])
    begin
      next_state = ST_IDLE;
    end
    if (sw_go || ext_go)
    begin
      next_state = ST_CONV;
      next_cyc = 6'd0;
      next_sub = 2'd0;
      next_sar = `SAR_MSB;
      next_mask = `SAR_MSB;
      next_div = 2'd0;
    end
  end

  always_ff @(posedge core_clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      trig_s1 <= 1'b1;
      trig_s2 <= 1'b1;
      trig_prev <= 1'b1;
      cmp_s1 <= 1'b0;
      cmp_s2 <= 1'b0;
      bus <= BUS_IDLE;
      avs_readdata_o <= 32'h00000000;
      avs_waitrequest_o <= 1'b1;
      ctrl <= `CTRL_RESET;
      irq_request_o <= 1'b0;
      state <= ST_IDLE;
      cyc <= 6'd0;
      sub <= 2'd0;
      sar <= '0;
      mask <= '0;
      div_cnt <= 2'd0;
      sample_o <= 1'b0;
      dac_code_o <= '0;
      channel_sel_o <= 3'd0;
      input_route_o <= 2'd0;
      chan_to_expanded_io_pin_0_o <= 1'b0;
      vref_connect_o <= 1'b0;
      busy_o <= 1'b0;
    end
    else
    begin
      trig_s1 <= ext_start_trigger_pin_i;
      trig_s2 <= trig_s1;
      trig_prev <= trig_s2;
      cmp_s1 <= comparator_i;
      cmp_s2 <= cmp_s1;
      bus <= next_bus;
      avs_readdata_o <= next_readdata;
      avs_waitrequest_o <= next_waitrequest;
      ctrl <= next_ctrl;
      irq_request_o <= next_irq;
      state <= next_state;
      cyc <= next_cyc;
      sub <= next_sub;
      sar <= next_sar;
      mask <= next_mask;
      div_cnt <= next_div;
      // without hold the switch stays closed for the whole conversion
      sample_o <= (next_state == ST_CONV)
                  && (next_cyc < `SAMPLE_CYC || !next_ctrl[`CTRL_SH]);
      dac_code_o <= next_sar;
      channel_sel_o <= next_ctrl[`CTRL_CHAN_MSB:`CTRL_CHAN_LSB];
      // op-amp mode converts the amplified voltage back on expanded pin 1
      input_route_o <= (next_ctrl[`CTRL_ROUTE_MSB:`CTRL_ROUTE_LSB] == ROUTE_OPAMP)
                       ? ROUTE_EXPANDED_INPUT_PIN_1
                       : next_ctrl[`CTRL_ROUTE_MSB:`CTRL_ROUTE_LSB];
      chan_to_expanded_io_pin_0_o <= (next_ctrl[`CTRL_ROUTE_MSB:`CTRL_ROUTE_LSB]
                                      == ROUTE_OPAMP);
      vref_connect_o <= next_ctrl[`CTRL_VREF];
      busy_o <= (next_state == ST_CONV);
    end
  end

  // ---------------- checks ----------------
  logic [7:0] clk_cnt;

  always_ff @(posedge core_clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      clk_cnt <= 8'd0;
    end
    else
    begin
      clk_cnt <= (sw_go || ext_go) ? 8'd0 : 8'(clk_cnt + 8'd1);
    end
  end

  default clocking cb @(posedge core_clk_i);
  endclocking
  default disable iff (!reset_n_i);

  AST_DIV4_SPACING: assert property (
    (state == ST_CONV && ctrl[`CTRL_FREQ_HI:`CTRL_FREQ_LO] == 2'b00 && phi_tick)
    |=> (!phi_tick || ctrl[`CTRL_FREQ_HI:`CTRL_FREQ_LO] != 2'b00) [*3]
    ##1 (phi_tick || state != ST_CONV || ctrl[`CTRL_FREQ_HI:`CTRL_FREQ_LO] != 2'b00
         || $past(sw_go || ext_go) || $past(sw_go || ext_go, 2)
         || $past(sw_go || ext_go, 3)))
    else $error("divide-by-four tick spacing wrong");

  AST_CONV_LENGTH: assert property (
    (done && ctrl[`CTRL_FREQ_HI:`CTRL_FREQ_LO] == 2'b00)
    |-> (clk_cnt == 8'(({2'b00, total} << 2) - 8'd1)))
    else $error("conversion length differs from the cycle count");

  AST_NOSH_LENGTH: assert property (
    (done && !ctrl[`CTRL_SH]) |-> (cyc == 6'd58 || cyc == 6'd48))
    else $error("conversion without hold has wrong length");

  AST_SAMPLE_WINDOW: assert property (
    (ctrl[`CTRL_SH] && $fell(sample_o) && busy_o) |-> (cyc == `SAMPLE_CYC))
    else $error("sampling did not last three operation cycles");

  AST_EIGHT_BIT_RANGE: assert property (
    (mem_we && !ctrl[`CTRL_RES10]) |-> (mem_wdata[9:8] == 2'b00))
    else $error("8-bit result exceeds 255");

  AST_SW_COMPLETE: assert property (
    (done && !ctrl[`CTRL_EXT_TRIG] && !ctrl_wr && !ext_go)
    |=> (!ctrl[`CTRL_START] && irq_request_o && state == ST_IDLE) ##1 !busy_o)
    else $error("software conversion did not finish properly");

  AST_SW_START: assert property (
    sw_go |=> (state == ST_CONV && cyc == 6'd0) ##1 busy_o)
    else $error("start flag write did not start a conversion");

  AST_EXT_START: assert property (
    (trig_fall && ctrl[`CTRL_EXT_TRIG] && ctrl[`CTRL_START] && !ctrl_wr)
    |=> (state == ST_CONV && cyc == 6'd0 && sar == `SAR_MSB))
    else $error("trigger edge did not start a conversion");

  AST_EXT_KEEP_FLAG: assert property (
    (done && ctrl[`CTRL_EXT_TRIG] && !ctrl_wr && !ext_go)
    |=> (ctrl[`CTRL_START] && state == ST_IDLE && irq_request_o))
    else $error("external conversion did not halt with flag kept");

  AST_NO_START_WITHOUT_FLAG: assert property (
    (state == ST_IDLE && !ctrl[`CTRL_START] && !(ctrl_wr && new_ctrl[`CTRL_START]))
    |=> (state == ST_IDLE))
    else $error("conversion began without the start flag");

  COV_SW_DONE: cover property (sw_go ##[1:300] done);
  COV_EXT_RESTART: cover property ((state == ST_CONV && cyc > 6'd5) ##0 ext_go);
  COV_8BIT_NOSH: cover property (done && !ctrl[`CTRL_RES10] && !ctrl[`CTRL_SH]);
  COV_OPAMP: cover property (done && route == ROUTE_OPAMP);

endmodule : adc_seq_oneshot

/* sim/adc_far_side.sv */
// far side of the converter: analog levels, comparator and trigger pin
// assumes: bench sets lvl and calls fall_trigger; edges of core_clk_i pace it
module adc_far_side import adc_seq_pkg::*;
(
  input wire logic core_clk_i,
  input wire logic [9:0] dac_code_i,
  input wire logic [2:0] channel_sel_i,
  input wire logic [1:0] input_route_i,
  input wire logic opamp_i,
  input wire logic sample_i,
  output logic comparator_o,
  output logic trigger_o
);
  timeunit 1ns;
  timeprecision 1ps;
  // analog pins are only read by the converter, never driven back
  logic [9:0] lvl [0:9];
  logic [9:0] live;
  logic [9:0] held = 10'h000;
  logic [9:0] chan;

  // op-amp taken as a doubling stage that clips at full scale
  always_comb
  begin
    chan = lvl[channel_sel_i];
    if (input_route_i == 2'd1)
      live = lvl[8];
    else if (input_route_i == 2'd2 && opamp_i)
      live = (chan > 10'h1ff) ? 10'h3ff : {chan[8:0], 1'b0};
    else if (input_route_i == 2'd2)
      live = lvl[9];
    else
      live = chan;
  end

  // once the switch opens the held level no longer follows the pin
  always_ff @(posedge core_clk_i)
    if (sample_i)
      held <= live;

  assign comparator_o = (held >= dac_code_i);

  initial trigger_o = 1'b1;

  // low for several clocks so the two-stage synchroniser surely sees it
  task automatic fall_trigger;
    @(posedge core_clk_i);
    trigger_o <= 1'b0;
    repeat (4) @(posedge core_clk_i);
    trigger_o <= 1'b1;
  endtask : fall_trigger
endmodule : adc_far_side

/* sim/test_adc_seq_oneshot.sv */
// self-checking bench of the one-shot converter sequencer
// assumes: design sources and adc_far_side compiled before this file
`include "adc_seq_defines.svh"

module test_adc_seq_oneshot import adc_seq_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [9:0] lv [0:9] = '{10'h000, 10'h3ff, 10'h200, 10'h1ff, 10'h155,
    10'h0c3, 10'h003, 10'h2aa, 10'h0f0, 10'h30c};
  logic clk;
  logic reset_n;
  logic [5:0] adr;
  logic rd;
  logic wr;
  logic [31:0] wdat;
  logic [31:0] rdat;
  logic wait_r;
  logic trig;
  logic cmp;
  logic smp;
  logic [9:0] dac;
  logic [2:0] chsel;
  logic [1:0] route;
  logic opamp;
  logic vref;
  logic irq;
  logic busy;
  int n_mismatch;
  int compares;

  adc_seq_oneshot dut_u
  (
    .core_clk_i(clk),
    .reset_n_i(reset_n),
    .avs_address_i(adr),
    .avs_read_i(rd),
    .avs_write_i(wr),
    .avs_writedata_i(wdat),
    .avs_byteenable_i(4'hf),
    .avs_readdata_o(rdat),
    .avs_waitrequest_o(wait_r),
    .ext_start_trigger_pin_i(trig),
    .comparator_i(cmp),
    .sample_o(smp),
    .dac_code_o(dac),
    .channel_sel_o(chsel),
    .input_route_o(route),
    .chan_to_expanded_io_pin_0_o(opamp),
    .vref_connect_o(vref),
    .irq_request_o(irq),
    .busy_o(busy)
  );

  adc_far_side fs_u
  (
    .core_clk_i(clk),
    .dac_code_i(dac),
    .channel_sel_i(chsel),
    .input_route_i(route),
    .opamp_i(opamp),
    .sample_i(smp),
    .comparator_o(cmp),
    .trigger_o(trig)
  );

  task automatic complete_run;
    if (n_mismatch == 0 && compares > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : complete_run

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check

  // request held until waitrequest is sampled low, then released
  task automatic bus(input logic w, input logic [5:0] a, input logic [31:0] d,
                     output logic [31:0] q);
    int n;
    n = 0;
    @(posedge clk);
    adr <= a;
    wdat <= d;
    rd <= ~w;
    wr <= w;
    do
    begin
      @(posedge clk);
      n++;
    end
    while (wait_r !== 1'b0 && n < 100);
    q = rdat;
    rd <= 1'b0;
    wr <= 1'b0;
    check(32'(n < 100), 32'h1);
  endtask : bus

  task automatic wreg(input logic [5:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask : wreg

  task automatic rreg(input logic [5:0] a, input logic [31:0] exp);
    logic [31:0] q;
    bus(1'b0, a, 32'h0, q);
    check(q, exp);
  endtask : rreg

  function automatic logic [31:0] ctl(input logic st, input logic ext, input logic r10,
    input logic sh, input logic [1:0] fq, input logic [2:0] ch, input logic [1:0] rt);
    ctl = {20'h0, 1'b1, rt, ch, fq, sh, r10, ext, st};
  endfunction : ctl

  task automatic wait_irq(output int nb, output int ns, output logic [9:0] first);
    int n;
    n = 0;
    nb = 0;
    ns = 0;
    first = 10'h000;
    while (irq !== 1'b1 && n < 600)
    begin
      @(negedge clk);
      n++;
      nb += int'(busy === 1'b1);
      ns += int'(smp === 1'b1);
      if (first === 10'h000 && dac !== 10'h000)
        first = dac;
    end
  endtask : wait_irq

  task automatic convert(input logic [31:0] c, input int cyc, input int smp_cyc);
    int nb;
    int ns;
    logic [9:0] first;
    wreg(`CTRL_OFS, c);
    wait_irq(nb, ns, first);
    check(32'(nb), 32'(cyc));
    check(32'(ns), 32'(smp_cyc));
    check(32'(first), 32'h200);
  endtask : convert

  initial
  begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  initial
  begin
    repeat (20000) @(posedge clk);
    n_mismatch++;
    $display("wrong value at %0t: watchdog expired", $time);
    complete_run();
  end

  initial
  begin
    logic [1:0] fq;
    logic r10;
    logic sh;
    logic [2:0] ch;
    int dv;
    int tot;
    int nb;
    int ns;
    logic [9:0] first;
    reset_n = 1'b0;
    adr = 6'h00;
    rd = 1'b0;
    wr = 1'b0;
    wdat = 32'h0;
    n_mismatch = 0;
    compares = 0;
    for (int i = 0; i < 10; i++)
      fs_u.lvl[i] = lv[i];
    repeat (16) @(posedge clk);
    reset_n <= 1'b1;
    check(32'({irq, busy}), 32'h0);
    rreg(`CTRL_OFS, 32'h0);
    rreg(`STAT_OFS, 32'h4);
    rreg(6'h10, 32'h0);
    wreg(`CTRL_OFS, ctl(0, 0, 0, 0, 2'b00, 3'd0, 2'd0));
    @(negedge clk);
    check(32'(vref), 32'h1);
    repeat (40) @(posedge clk);
    // every divider code, both resolutions, both sample modes, every channel
    for (int k = 0; k < 16; k++)
    begin
      fq = 2'(k);
      sh = k[2];
      r10 = k[3];
      ch = 3'(k) + 3'(k >> 3);
      dv = fq[1] ? 1 : (fq[0] ? 2 : 4);
      tot = sh ? (r10 ? 33 : 28) : (r10 ? 59 : 49);
      // all dividers stay at 10 MHz or above, so sample-and-hold is legal
      convert(ctl(1, 0, r10, sh, fq, ch, 2'd0), tot * dv, sh ? 3 * dv : tot * dv);
      check(32'(chsel), 32'(ch));
      rreg({1'b1, ch, 2'b00}, 32'(r10 ? lv[ch] : lv[ch] >> 2));
      rreg(`CTRL_OFS, ctl(0, 0, r10, sh, fq, ch, 2'd0));
      rreg(`STAT_OFS, 32'h6);
      wreg(`STAT_OFS, 32'h2);
      @(negedge clk);
      check(32'(irq), 32'h0);
    end
    // expanded pin 0, expanded pin 1, then the op-amp loop on channel 5
    for (int r = 1; r < 4; r++)
    begin
      convert(ctl(1, 0, 1, 1, 2'b10, 3'd5, 2'(r)), 33, 3);
      check(32'(route), (r == 1) ? 32'h1 : 32'h2);
      rreg((r == 1) ? 6'h20 : ((r == 2) ? 6'h24 : 6'h34),
        32'((r == 1) ? lv[8] : ((r == 2) ? lv[9] : 10'h186)));
      wreg(`STAT_OFS, 32'h2);
    end
    wreg(`CTRL_OFS, ctl(1, 1, 1, 1, 2'b00, 3'd2, 2'd0));
    repeat (20) @(posedge clk);
    check(32'(busy), 32'h0);
    fs_u.fall_trigger();
    repeat (60) @(posedge clk);
    check(32'(busy), 32'h1);
    // second edge lands mid-conversion; the first would have ended by the check
    fs_u.fall_trigger();
    repeat (80) @(posedge clk);
    check(32'({busy, irq}), 32'h2);
    wait_irq(nb, ns, first);
    check(32'(irq), 32'h1);
    rreg(6'h28, 32'(lv[2]));
    rreg(`CTRL_OFS, ctl(1, 1, 1, 1, 2'b00, 3'd2, 2'd0));
    wreg(`STAT_OFS, 32'h2);
    @(posedge clk);
    fs_u.lvl[2] <= 10'h155;
    // busy rises inside the trigger pulse, so counting starts before it
    fork
      fs_u.fall_trigger();
    join_none
    wait_irq(nb, ns, first);
    check(32'(nb), 32'd132);
    rreg(6'h28, 32'h155);
    wreg(`STAT_OFS, 32'h2);
    wreg(`CTRL_OFS, ctl(0, 1, 1, 1, 2'b00, 3'd2, 2'd0));
    fs_u.fall_trigger();
    repeat (40) @(posedge clk);
    check(32'({busy, irq}), 32'h0);
    complete_run();
  end
endmodule : test_adc_seq_oneshot
